// >>> hw/bps_pkg.sv
// Functional notes
// - Enter battery mode only if main below backup-minus-hysteresis and below trip level.
// - Return to normal when main above backup-plus-hysteresis or above trip plus hysteresis.
// - In battery mode the serial port ignores its inputs and never pulls data low.
// - Everything but the serial port keeps working on battery unless disabled.
// - Capture time on each switchover; first power-down kept, last power-up kept.
// - Power-down capture held until the capture clear bit wipes the captures.
// - A flag shows power-up after loss of both supplies.
// - Brownout flag set when main supply falls below the chosen trip level.
// - Six brownout trip levels selectable by a setting.
// - Between thresholds set first battery-low flag; below lower set both flags.
// - Brownout alone leaves the serial port active until the trip condition.
// - On battery, temperature conversion runs only with battery sense enable set.
// - Frequency-output bits choose interrupt or clock function on the shared pin.
// - Interrupt function drives the shared open-drain pin low for an alarm.
// - Alarm is readable as a flag and may also drive the interrupt pin.
// - Repeating alarm mode raises an interrupt on every recurring match.
// - Alarm is disabled while the shared pin gives a clock output.
// - Repeating alarm holds the pin low 250 ms per match and sets alarm flag.
package bps_pkg;

    // -------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS   = 40;
    localparam int unsigned FILTER_TIME_NS  = 2000;
    localparam int unsigned FILTER_CYC      =
        (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned FILTER_CNT_W    = 8;
    localparam int unsigned ALARM_PULSE_MS  = 250;
    localparam int unsigned ALARM_PULSE_CYC = (ALARM_PULSE_MS * 1000000) / CLK_PERIOD_NS;
    localparam int unsigned PULSE_CNT_W     = 24;

    // -------------------------------------------------------------------
    // Widths, codes and reset values
    // -------------------------------------------------------------------
    localparam int unsigned BO_LEVELS      = 6;
    localparam logic [2:0]  BO_TOP         = 3'h5;
    localparam int unsigned STAMP_W        = 40;
    localparam logic [3:0]  FREQ_OFF       = 4'h0;
    localparam logic        TOTAL_LOSS_RST = 1'b1;

    typedef logic [STAMP_W-1:0] stamp_t;

    typedef enum logic [1:0] {
        ST_NORMAL  = 2'b01,
        ST_BATTERY = 2'b10
    } pmode_e;

    // Comparator results, one bit per analog decision
    typedef struct packed {
        logic                 below_bat_hys;
        logic                 above_bat_hys;
        logic                 below_trip;
        logic                 above_trip_hys;
        logic [BO_LEVELS-1:0] below_bo;
        logic                 bat_below_85;
        logic                 bat_below_75;
    } cmp_s;

    // Status flags
    typedef struct packed {
        logic alarm;
        logic brownout;
        logic bat_first;
        logic bat_second;
        logic total_loss;
    } status_s;

endpackage

// >>> hw/cmp_filter.sv
`timescale 1ns/100ps
`default_nettype none

module cmp_filter #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input  wire logic         mclk_i,
    input  wire logic         rst_i,
    // Raw and filtered comparator bits
    input  wire logic [W-1:0] raw_i,
    output logic      [W-1:0] clean_o
);

    localparam logic [bps_pkg::FILTER_CNT_W-1:0] CNT_END =
        bps_pkg::FILTER_CNT_W'(bps_pkg::FILTER_CYC - 1);

    logic [W-1:0]                     meta_q;
    logic [W-1:0]                     sync_q;
    logic [W-1:0]                     last_q;
    logic [W-1:0]                     clean_q;
    logic [bps_pkg::FILTER_CNT_W-1:0] cnt_q;

    // Two-stage synchroniser, first stage read only by the second
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            meta_q <= '0;
            sync_q <= '0;
            last_q <= '0;
        end
        else
        begin
            meta_q <= raw_i;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    // Stability counter restarts on any change
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            cnt_q <= '0;
        else if (sync_q != last_q)
            cnt_q <= '0;
        else if (cnt_q != CNT_END)
            cnt_q <= cnt_q + 1'b1;
    end

    // Accept a value only after it stood for the whole filter time
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            clean_q <= '0;
        else if (sync_q == last_q && cnt_q == CNT_END)
            clean_q <= last_q;
    end

    assign clean_o = clean_q;

endmodule
`default_nettype wire

// >>> hw/backup_power_supervisor.sv
`timescale 1ns/100ps
`default_nettype none

module backup_power_supervisor #(
    parameter int unsigned PULSE_CYCLES = bps_pkg::ALARM_PULSE_CYC
) (
    // Clock and reset
    input  wire logic             mclk_i,
    input  wire logic             rst_i,
    // Analog comparator results
    input  wire bps_pkg::cmp_s    cmp_i,
    input  wire logic [2:0]       bo_level_sel_i,
    // Flag clearing and time capture
    input  wire bps_pkg::status_s flag_clr_i,
    input  wire logic             capture_clear_bit_i,
    input  wire bps_pkg::stamp_t  time_now_i,
    // Serial host port pins and engine
    input  wire logic             scl_i,
    input  wire logic             sda_i,
    input  wire logic             sda_drive_i,
    // Temperature sensing control
    input  wire logic             temp_sense_enable_i,
    input  wire logic             battery_temp_sense_enable_i,
    // Shared pin and alarm control
    input  wire logic             fout_bat_disable_i,
    input  wire logic [3:0]       freq_sel_i,
    input  wire logic             freq_clk_i,
    input  wire logic             alarm_enable_i,
    input  wire logic             alarm_pulse_mode_i,
    input  wire logic             alarm_match_i,
    // Mode and serial gating
    output logic                  battery_mode_o,
    output logic                  scl_gated_o,
    output logic                  sda_gated_o,
    output logic                  sda_oe_o,
    // Status and captures
    output bps_pkg::status_s      status_o,
    output bps_pkg::stamp_t       powerdown_time_capture_o,
    output bps_pkg::stamp_t       powerup_time_capture_o,
    output logic                  temp_conv_run_o,
    // Shared open-drain pin
    output logic                  interrupt_or_clock_pin_o,
    output logic                  interrupt_or_clock_pin_oe_o
);

    // -------------------------------------------------------------------
    // Declarations
    // -------------------------------------------------------------------
    localparam logic [bps_pkg::PULSE_CNT_W-1:0] PULSE_LOAD =
        bps_pkg::PULSE_CNT_W'(PULSE_CYCLES);

    bps_pkg::cmp_s                  cmp_f;
    bps_pkg::pmode_e                mode_q;
    bps_pkg::pmode_e                mode_d;
    bps_pkg::status_s               stat_q;
    bps_pkg::stamp_t                pd_cap_q;
    bps_pkg::stamp_t                pu_cap_q;
    logic                           pd_valid_q;
    logic                           bat_q;
    logic                           bat_d;
    logic                           enter_w;
    logic                           leave_w;
    logic                           scl_q;
    logic                           sda_q;
    logic                           sda_oe_q;
    logic                           temp_q;
    logic                           pin_q;
    logic                           pin_oe_q;
    logic [2:0]                     bo_idx;
    logic                           fout_mode;
    logic                           pin_allowed;
    logic                           alarm_active;
    logic                           match_take;
    logic                           irq_low_d;
    logic [bps_pkg::PULSE_CNT_W-1:0] pulse_cnt_q;
    logic [bps_pkg::PULSE_CNT_W-1:0] pulse_cnt_d;

    // Sticky flag update where a set beats a clear in the same cycle
    function automatic logic sticky(input logic q, input logic set, input logic clr);
        return set | (q & ~clr);
    endfunction

    // -------------------------------------------------------------------
    // Comparator conditioning
    // -------------------------------------------------------------------
    // Synchronise and debounce every comparator bit
    cmp_filter #(
        .W($bits(bps_pkg::cmp_s))
    ) u_filter (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .raw_i   (cmp_i),
        .clean_o (cmp_f)
    );

    // -------------------------------------------------------------------
    // Supply mode
    // -------------------------------------------------------------------
    // Mode decision with separate entry and exit conditions
    always_comb
    begin
        mode_d = mode_q;
        unique case (mode_q)
            bps_pkg::ST_NORMAL:
                if (cmp_f.below_bat_hys && cmp_f.below_trip)
                    mode_d = bps_pkg::ST_BATTERY;
            bps_pkg::ST_BATTERY:
                if (cmp_f.above_bat_hys || cmp_f.above_trip_hys)
                    mode_d = bps_pkg::ST_NORMAL;
            default:
                mode_d = bps_pkg::ST_NORMAL;
        endcase
    end

    assign bat_d   = (mode_d == bps_pkg::ST_BATTERY);
    assign enter_w = (mode_q == bps_pkg::ST_NORMAL) && bat_d;
    assign leave_w = (mode_q == bps_pkg::ST_BATTERY) && !bat_d;

    // Mode register and its one-bit copy for the output
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            mode_q <= bps_pkg::ST_NORMAL;
            bat_q  <= 1'b0;
        end
        else
        begin
            mode_q <= mode_d;
            bat_q  <= bat_d;
        end
    end

    // -------------------------------------------------------------------
    // Serial port gating
    // -------------------------------------------------------------------
    // Brownout does not touch the port; only battery mode idles it
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            scl_q    <= 1'b1;
            sda_q    <= 1'b1;
            sda_oe_q <= 1'b0;
        end
        else
        begin
            scl_q    <= scl_i || bat_d;
            sda_q    <= sda_i || bat_d;
            sda_oe_q <= sda_drive_i && !bat_d;
        end
    end

    // -------------------------------------------------------------------
    // Time stamps
    // -------------------------------------------------------------------
    // First power-down kept; a clear in the same cycle lets a new one in
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pd_cap_q   <= '0;
            pd_valid_q <= 1'b0;
        end
        else if (enter_w && (!pd_valid_q || capture_clear_bit_i))
        begin
            pd_cap_q   <= time_now_i;
            pd_valid_q <= 1'b1;
        end
        else if (capture_clear_bit_i)
        begin
            pd_cap_q   <= '0;
            pd_valid_q <= 1'b0;
        end
    end

    // Power-up capture holds the latest return to main supply until the capture clear bit wipes it
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            pu_cap_q <= '0;
        else if (leave_w)
            pu_cap_q <= time_now_i;
        else if (capture_clear_bit_i)
            pu_cap_q <= '0;
    end

    // -------------------------------------------------------------------
    // Supply status flags
    // -------------------------------------------------------------------
    // Out-of-range selections fall back to the highest level
    assign bo_idx = (bo_level_sel_i > bps_pkg::BO_TOP) ? bps_pkg::BO_TOP : bo_level_sel_i;

    // Power-loss flag is set only by reset; the others follow their set events
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            stat_q.total_loss <= bps_pkg::TOTAL_LOSS_RST;
            stat_q.brownout   <= 1'b0;
            stat_q.bat_first  <= 1'b0;
            stat_q.bat_second <= 1'b0;
            stat_q.alarm      <= 1'b0;
        end
        else
        begin
            stat_q.total_loss <= sticky(stat_q.total_loss, 1'b0,
                                        flag_clr_i.total_loss);
            stat_q.brownout   <= sticky(stat_q.brownout, cmp_f.below_bo[bo_idx],
                                        flag_clr_i.brownout);
            stat_q.bat_first  <= sticky(stat_q.bat_first, cmp_f.bat_below_85,
                                        flag_clr_i.bat_first);
            stat_q.bat_second <= sticky(stat_q.bat_second, cmp_f.bat_below_75,
                                        flag_clr_i.bat_second);
            stat_q.alarm      <= sticky(stat_q.alarm, match_take, flag_clr_i.alarm);
        end
    end

    // -------------------------------------------------------------------
    // Temperature conversion gate
    // -------------------------------------------------------------------
    // Runs on main supply when enabled; on battery needs the extra enable
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            temp_q <= 1'b0;
        else
            temp_q <= temp_sense_enable_i &&
                      (!bat_d || battery_temp_sense_enable_i);
    end

    // -------------------------------------------------------------------
    // Alarm and shared pin
    // -------------------------------------------------------------------
    // Clock output mode takes the pin and turns the alarm off
    assign fout_mode    = (freq_sel_i != bps_pkg::FREQ_OFF);
    assign pin_allowed  = !(bat_q && fout_bat_disable_i);
    assign alarm_active = alarm_enable_i && !fout_mode && pin_allowed;
    assign match_take   = alarm_match_i && alarm_active;

    // Repeating mode reloads the low time on every match
    always_comb
    begin
        pulse_cnt_d = pulse_cnt_q;
        if (match_take && alarm_pulse_mode_i)
            pulse_cnt_d = PULSE_LOAD;
        else if (pulse_cnt_q != '0)
            pulse_cnt_d = pulse_cnt_q - 1'b1;
    end

    // Single mode holds the pin low for as long as the flag stands
    assign irq_low_d = alarm_pulse_mode_i ? (pulse_cnt_d != '0)
                     : (alarm_active && sticky(stat_q.alarm, match_take, flag_clr_i.alarm));

    // Repeat pulse counter
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            pulse_cnt_q <= '0;
        else
            pulse_cnt_q <= pulse_cnt_d;
    end

    // Open-drain pin: only ever pulls low, enable high while pulling
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pin_q    <= 1'b0;
            pin_oe_q <= 1'b0;
        end
        else
        begin
            pin_q    <= 1'b0;
            pin_oe_q <= pin_allowed &&
                        (fout_mode ? !freq_clk_i : irq_low_d);
        end
    end

    // -------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------
    assign battery_mode_o              = bat_q;
    assign scl_gated_o                 = scl_q;
    assign sda_gated_o                 = sda_q;
    assign sda_oe_o                    = sda_oe_q;
    assign status_o                    = stat_q;
    assign powerdown_time_capture_o    = pd_cap_q;
    assign powerup_time_capture_o      = pu_cap_q;
    assign temp_conv_run_o             = temp_q;
    assign interrupt_or_clock_pin_o    = pin_q;
    assign interrupt_or_clock_pin_oe_o = pin_oe_q;

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);

    a_enter_battery: assert property (
        mode_q == bps_pkg::ST_NORMAL && cmp_f.below_bat_hys && cmp_f.below_trip |=> bat_q)
        else $error("battery mode not entered");

    a_stay_normal: assert property (
        mode_q == bps_pkg::ST_NORMAL && !cmp_f.below_trip
        |=> !bat_q && sda_oe_o == $past(sda_drive_i))
        else $error("left normal mode above trip level");

    a_leave_battery: assert property (
        mode_q == bps_pkg::ST_BATTERY && (cmp_f.above_bat_hys || cmp_f.above_trip_hys)
        |=> !bat_q)
        else $error("battery mode not left");

    a_port_idle: assert property (
        bat_q |-> !sda_oe_o && scl_gated_o && sda_gated_o)
        else $error("serial port active on battery");

    a_pd_first: assert property (
        $rose(bat_q) && !$past(pd_valid_q) |-> pd_cap_q == $past(time_now_i))
        else $error("power-down time not captured");

    a_pd_kept: assert property (
        $rose(bat_q) && $past(pd_valid_q) && !$past(capture_clear_bit_i) |-> $stable(pd_cap_q))
        else $error("first power-down time overwritten");

    a_pu_last: assert property (
        $fell(bat_q) |-> pu_cap_q == $past(time_now_i))
        else $error("power-up time not captured");

    a_capture_clear: assert property (
        capture_clear_bit_i && mode_d == mode_q |=> pd_cap_q == '0 && pu_cap_q == '0)
        else $error("captures not cleared");

    a_loss_held: assert property (
        status_o.total_loss && !flag_clr_i.total_loss |=> status_o.total_loss)
        else $error("power-loss flag dropped");

    a_brownout_set: assert property (
        cmp_f.below_bo[bo_idx] |=> status_o.brownout)
        else $error("brownout flag not set");

    a_bat_both: assert property (
        cmp_f.bat_below_85 && cmp_f.bat_below_75 |=> status_o.bat_first && status_o.bat_second)
        else $error("battery-low flags not both set");

    a_temp_battery: assert property (
        bat_q && temp_conv_run_o |-> $past(battery_temp_sense_enable_i))
        else $error("temperature run on battery without enable");

    a_alarm_off: assert property (
        fout_mode && !status_o.alarm |=> !status_o.alarm)
        else $error("alarm raised in clock output mode");

    a_pulse_load: assert property (
        match_take && alarm_pulse_mode_i |=> pulse_cnt_q == PULSE_LOAD && status_o.alarm)
        else $error("repeat alarm pulse not started");

    a_pulse_count: assert property (
        pulse_cnt_q > 1 && !match_take |=> pulse_cnt_q == $past(pulse_cnt_q) - 1'b1)
        else $error("repeat alarm pulse miscounted");

    c_enter: cover property (enter_w);
    c_leave: cover property (leave_w);
    c_pd_kept: cover property (enter_w && pd_valid_q);
    c_pulse_end: cover property (pulse_cnt_q == 1 && !match_take);

endmodule
`default_nettype wire

// >>> tb/i2c_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module i2c_host_model (
    // Host requests to pull the lines low
    input  wire logic scl_low_i,
    input  wire logic sda_low_i,
    // Device pull-down on the data line
    input  wire logic dev_sda_oe_i,
    // Resolved bus lines
    output logic      scl_o,
    output logic      sda_o
);
    // Open-drain lines with pull-ups: released means high, never the last value
    assign scl_o = !scl_low_i;
    assign sda_o = !(sda_low_i || dev_sda_oe_i);
endmodule

`default_nettype wire

// >>> tb/backup_power_supervisor_bench.sv
`timescale 1ns/100ps
`default_nettype none

module backup_power_supervisor_bench;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic             mclk_i = 1'b0;
    logic             rst_i = 1'b1;
    bps_pkg::cmp_s    cmp = '0;
    bps_pkg::status_s clr = '0;
    bps_pkg::stamp_t  tnow = '0;
    logic [2:0]       bo_sel = 3'h0;
    logic [3:0]       fsel = bps_pkg::FREQ_OFF;
    logic             cap_clr = 1'b0, scl_low = 1'b0, sda_low = 1'b0, sda_drv = 1'b0;
    logic             temp_sense_enable = 1'b1, battery_temp_sense_enable = 1'b0, fdis = 1'b0, fclk = 1'b0;
    logic             alm_en = 1'b1, alm_pm = 1'b1, match = 1'b0;
    logic             scl, sda, bmode, scl_g, sda_g, sda_oe, trun, pin, pin_oe;
    bps_pkg::status_s st;
    bps_pkg::stamp_t  pd_cap, pu_cap;
    int               failures = 0;
    int               checks_done = 0;
    int               n;
    // Mode expected in bit 12 beside the comparator word
    logic [12:0]      rows [7] = '{13'h0800, 13'h0200, 13'h1a00, 13'h0400,
                                   13'h1a00, 13'h0100, 13'h0900};

    // Clock
    always #20 mclk_i = !mclk_i;

    i2c_host_model host_u (.scl_low_i(scl_low), .sda_low_i(sda_low),
        .dev_sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));

    backup_power_supervisor #(.PULSE_CYCLES(20)) dut_u (
        .mclk_i(mclk_i), .rst_i(rst_i), .cmp_i(cmp), .bo_level_sel_i(bo_sel),
        .flag_clr_i(clr), .capture_clear_bit_i(cap_clr), .time_now_i(tnow),
        .scl_i(scl), .sda_i(sda), .sda_drive_i(sda_drv),
        .temp_sense_enable_i(temp_sense_enable), .battery_temp_sense_enable_i(battery_temp_sense_enable),
        .fout_bat_disable_i(fdis), .freq_sel_i(fsel), .freq_clk_i(fclk),
        .alarm_enable_i(alm_en), .alarm_pulse_mode_i(alm_pm), .alarm_match_i(match),
        .battery_mode_o(bmode), .scl_gated_o(scl_g), .sda_gated_o(sda_g),
        .sda_oe_o(sda_oe), .status_o(st), .powerdown_time_capture_o(pd_cap),
        .powerup_time_capture_o(pu_cap), .temp_conv_run_o(trun),
        .interrupt_or_clock_pin_o(pin), .interrupt_or_clock_pin_oe_o(pin_oe));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Wait k edges, then step just past the edge
    task automatic cyc(input int k);
        repeat (k) @(posedge mclk_i);
        #1;
    endtask

    task automatic end_sim;
        if (failures == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Hang guard
    initial
    begin
        repeat (20000) @(posedge mclk_i);
        failures++;
        end_sim;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        cyc(8);
        rst_i = 1'b0;
        cyc(2);
        chk(st, 40'h01);
        clr.total_loss = 1'b1;
        cyc(1);
        clr = '0;
        chk(st.total_loss, 40'h0);
        // Switchover table, filter settles within 70 cycles
        for (int i = 0; i < 7; i++)
        begin
            tnow = 40'(i);
            cmp = bps_pkg::cmp_s'(rows[i][11:0]);
            cyc(70);
            chk(bmode, rows[i][12]);
        end
        chk(pd_cap, 40'h2);
        chk(pu_cap, 40'h5);
        cap_clr = 1'b1;
        cyc(1);
        cap_clr = 1'b0;
        chk({pd_cap, pu_cap} == '0, 40'h1);
        // Battery mode with host pulling both lines
        {scl_low, sda_low, sda_drv, tnow} = {3'h7, 40'h9};
        cmp = bps_pkg::cmp_s'(12'ha00);
        cyc(70);
        chk({bmode, scl_g, sda_g, sda_oe, trun}, 40'h1c);
        chk(pd_cap, 40'h9);
        battery_temp_sense_enable = 1'b1;
        cyc(2);
        chk(trun, 40'h1);
        // Repeating alarm on battery
        match = 1'b1;
        cyc(1);
        match = 1'b0;
        chk(st.alarm, 40'h1);
        n = 0;
        for (int k = 0; k < 40; k++)
        begin
            n += pin_oe;
            cyc(1);
        end
        chk(40'(n), 40'd20);
        {fdis, clr.alarm, match} = 3'h7;
        cyc(1);
        {clr.alarm, match} = 2'h0;
        cyc(2);
        chk({st.alarm, pin_oe}, 40'h0);
        // Return to normal
        {fdis, tnow} = {1'b0, 40'hc};
        cmp = bps_pkg::cmp_s'(12'h400);
        cyc(70);
        chk({bmode, scl_g, sda_g, sda_oe}, 40'h1);
        chk(pd_cap, 40'h9);
        chk(pu_cap, 40'hc);
        // Host lets go; the device's own pull still holds data low
        {scl_low, sda_low} = 2'h0;
        cyc(2);
        chk({scl_g, sda_g}, 40'h2);
        // Brownout levels, serial port stays awake
        for (int s = 0; s < 6; s++)
        begin
            bo_sel = 3'(s);
            cmp.below_bo = ~(6'h01 << s);
            cyc(70);
            chk(st.brownout, 40'h0);
            cmp.below_bo = 6'h01 << s;
            cyc(70);
            chk({st.brownout, bmode, sda_oe}, 40'h5);
            cmp.below_bo = '0;
            cyc(70);
            clr.brownout = 1'b1;
            cyc(1);
            clr = '0;
        end
        // Selections above the top level act as the top level
        {bo_sel, cmp.below_bo} = {3'h7, 6'h20};
        cyc(70);
        chk(st.brownout, 40'h1);
        // Battery level flags
        cmp.bat_below_85 = 1'b1;
        cyc(70);
        chk({st.bat_first, st.bat_second}, 40'h2);
        cmp.bat_below_75 = 1'b1;
        cyc(70);
        chk({st.bat_first, st.bat_second}, 40'h3);
        // Single event alarm holds the pin until cleared
        {alm_pm, match} = 2'h1;
        cyc(1);
        match = 1'b0;
        cyc(30);
        chk({st.alarm, pin_oe, pin}, 40'h6);
        clr.alarm = 1'b1;
        cyc(1);
        clr = '0;
        cyc(1);
        chk(pin_oe, 40'h0);
        // Clock output mode blocks the alarm
        fsel = 4'h1;
        cyc(2);
        chk(pin_oe, 40'h1);
        {fclk, match} = 2'h3;
        cyc(1);
        match = 1'b0;
        cyc(1);
        chk({st.alarm, pin_oe}, 40'h0);
        // Reset in mid-run returns every output to its idle value
        rst_i = 1'b1;
        cyc(1);
        chk({bmode, scl_g, sda_g, sda_oe, trun, pin_oe, pin}, 40'h30);
        chk({pd_cap, pu_cap} == '0, 40'h1);
        rst_i = 1'b0;
        cyc(2);
        chk(st, 40'h01);
        end_sim;
    end
endmodule

`default_nettype wire
